// File: rtl/alm_regs.sv
// Purpose: analog low limit, measured value and miscellaneous register bank
// Assumes: one clock, synchronous reset, plain register port with read data one cycle later
// Notes: a soft reset returns the limit, behaviour, test and measured registers to their reset values, the key register only once the soft reset has run
`timescale 1ns/1ps
`default_nettype none
module alm_regs #(
   parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
   parameter logic [3:0] REV_MAJOR = 4'h0, // major revision
   parameter logic [3:0] REV_MINOR = 4'h0 // minor revision
) (
   input wire logic clk_sys, // system clock
   input wire logic reset, // hard reset, active high
   input wire logic ce, // clock enable
   input wire alm_pkg::alm_bus_t bus_in, // register request
   input wire alm_pkg::alm_meas_t [1:0] meas_in, // conversion results
   output logic [7:0] rd_data, // read data, cycle after read
   output logic [1:0] low_event, // limit crossed per channel
   output logic [1:0] fault_latched, // sticky fault per channel
   output logic soft_reset_out // soft reset in progress
);
   typedef struct packed {
      logic [1:0][7:0] low_lim;
      logic [1:0][7:0] behav;
      logic [7:0] test_reg;
      logic [7:0] key_reg;
      logic [7:0] rd_data;
   } alm_regs_state_t;

   alm_regs_state_t q;
   alm_regs_state_t next_q;

   logic sr_active;
   logic sr_done;
   logic key_hit;
   logic rst_ch;
   logic [1:0][7:0] ch_meas;
   logic [1:0] ch_event;
   logic [7:0] rd_mux;

   // key value written while no soft reset is running
   assign key_hit = bus_in.wr && !sr_active
      && (bus_in.addr == alm_pkg::ADDR_SWRST)
      && (bus_in.wdata == alm_pkg::SWRST_KEY);

   // channels follow both hard and soft reset
   assign rst_ch = reset | sr_active;

   // soft reset sequencer
   alm_swrst u_swrst (
      .clk_sys(clk_sys),
      .reset(reset),
      .ce(ce),
      .key_hit(key_hit),
      .soft_rst(sr_active),
      .done(sr_done)
   );

   // one limit checker per channel
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         alm_chan u_chan (
            .clk_sys(clk_sys),
            .rst(rst_ch),
            .ce(ce),
            .meas(meas_in[gi]),
            .low_limit(q.low_lim[gi]),
            .above_sel(q.behav[gi][alm_pkg::BEHAV_DIR_BIT]),
            .measured(ch_meas[gi]),
            .low_event(ch_event[gi])
         );
      end
   endgenerate

   // read multiplexer; unmapped offsets read zero
   always_comb begin
      case (bus_in.addr)
         alm_pkg::ADDR_SWRST: rd_mux = q.key_reg;
         alm_pkg::ADDR_MAKER: rd_mux = MAKER_ID;
         alm_pkg::ADDR_REV: rd_mux = {REV_MAJOR, REV_MINOR};
         alm_pkg::ADDR_TEST: rd_mux = q.test_reg;
         alm_pkg::ADDR_BEHAV0: rd_mux = q.behav[0];
         alm_pkg::ADDR_BEHAV1: rd_mux = q.behav[1];
         alm_pkg::ADDR_LOW0: rd_mux = q.low_lim[0];
         alm_pkg::ADDR_LOW1: rd_mux = q.low_lim[1];
         alm_pkg::ADDR_MEAS0: rd_mux = ch_meas[0];
         alm_pkg::ADDR_MEAS1: rd_mux = ch_meas[1];
         default: rd_mux = alm_pkg::RD_NONE;
      endcase
   end

   // next state of the register bank
   always_comb begin
      next_q = q;
      // key register clears once the soft reset has run
      if (sr_done) begin
         next_q.key_reg = alm_pkg::RST_KEY;
      end
      // writes; ignored while the soft reset runs
      if (bus_in.wr && !sr_active) begin
         case (bus_in.addr)
            alm_pkg::ADDR_SWRST: next_q.key_reg = bus_in.wdata;
            alm_pkg::ADDR_TEST: next_q.test_reg = bus_in.wdata;
            alm_pkg::ADDR_BEHAV0: next_q.behav[0] = bus_in.wdata;
            alm_pkg::ADDR_BEHAV1: next_q.behav[1] = bus_in.wdata;
            alm_pkg::ADDR_LOW0: next_q.low_lim[0] = bus_in.wdata;
            alm_pkg::ADDR_LOW1: next_q.low_lim[1] = bus_in.wdata;
            default: begin
               // maker, revision and measured registers ignore writes
            end
         endcase
      end
      // a channel event sets its sticky bit; the set beats a clearing write
      for (int i = 0; i < 2; i++) begin
         if (ch_event[i]) begin
            next_q.behav[i][alm_pkg::BEHAV_LATCH_BIT] = 1'b1;
         end
      end
      // soft reset puts the limit, behaviour and test registers back to their reset values
      if (sr_active) begin
         next_q.low_lim = {2{alm_pkg::RST_LOW}};
         next_q.behav = {2{alm_pkg::RST_BEHAV}};
         next_q.test_reg = alm_pkg::RST_TEST;
      end
      // read data stand only in the cycle after the strobe
      next_q.rd_data = bus_in.rd ? rd_mux : alm_pkg::RD_NONE;
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '{
            low_lim: {2{alm_pkg::RST_LOW}},
            behav: {2{alm_pkg::RST_BEHAV}},
            test_reg: alm_pkg::RST_TEST,
            key_reg: alm_pkg::RST_KEY,
            rd_data: alm_pkg::RD_NONE
         };
      end else if (ce) begin
         q <= next_q;
      end
   end

   // outputs, all from flip-flops
   assign rd_data = q.rd_data;
   assign low_event = ch_event;
   assign soft_reset_out = sr_active;
   assign fault_latched = {q.behav[1][alm_pkg::BEHAV_LATCH_BIT], q.behav[0][alm_pkg::BEHAV_LATCH_BIT]};

   // checks on the register bank
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // low limit takes the written byte
   a_low_limit_write: assert property (
      ce && bus_in.wr && !sr_active && bus_in.addr == alm_pkg::ADDR_LOW1
      |=> q.low_lim[1] == $past(bus_in.wdata)
   ) else $error("low limit one did not take the written value");

   // low limits are zero right after hard reset
   a_low_limit_reset: assert property (
      $past(reset) |-> q.low_lim[0] == alm_pkg::RST_LOW && q.low_lim[1] == alm_pkg::RST_LOW
   ) else $error("low limits not zero after reset");

   // measured value read returns the stored result
   a_meas_read_back: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_MEAS0
      |=> rd_data == $past(ch_meas[0])
   ) else $error("measured value read mismatch");

   // conversion result is captured
   a_meas_capture: assert property (
      ce && !sr_active && meas_in[1].valid
      |=> ch_meas[1] == $past(meas_in[1].value)
   ) else $error("measured value not captured");

   // key write starts a soft reset that clears the limits
   a_key_soft_reset: assert property (
      ce && key_hit ##1 ce [*4]
      |=> !sr_active && q.low_lim == {2{alm_pkg::RST_LOW}} && q.test_reg == alm_pkg::RST_TEST
   ) else $error("key write did not reset the registers");

   // key register reads zero after the reset completes
   a_key_self_clear: assert property (
      ce && sr_done && !(bus_in.wr && bus_in.addr == alm_pkg::ADDR_SWRST)
      |=> q.key_reg == alm_pkg::RST_KEY
   ) else $error("soft reset register did not clear");

   // maker code is fixed
   a_maker_read: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_MAKER |=> rd_data == MAKER_ID
   ) else $error("maker code read mismatch");

   // minor revision in the low nibble
   a_rev_minor: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_REV
      |=> rd_data[alm_pkg::REV_MINOR_LSB +: 4] == REV_MINOR
   ) else $error("minor revision mismatch");

   // major revision in the high nibble
   a_rev_major: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_REV
      |=> rd_data[alm_pkg::REV_MAJOR_LSB +: 4] == REV_MAJOR
   ) else $error("major revision mismatch");

   // event follows the chosen direction
   a_event_direction: assert property (
      ce && !sr_active
      |=> low_event[0] == ($past(q.behav[0][alm_pkg::BEHAV_DIR_BIT])
         ? ($past(ch_meas[0]) > $past(q.low_lim[0]))
         : ($past(ch_meas[0]) < $past(q.low_lim[0])))
   ) else $error("low limit event direction wrong");

   // an event sets the sticky bit
   a_event_latch: assert property (
      ce && !sr_active && low_event[1] |=> fault_latched[1]
   ) else $error("channel fault not latched");

   // low limit zero takes the written byte
   a_low0_write: assert property (
      ce && bus_in.wr && !sr_active && bus_in.addr == alm_pkg::ADDR_LOW0
      |=> q.low_lim[0] == $past(bus_in.wdata)
   ) else $error("low limit zero did not take the written value");

   // low limit zero holds without a write to it
   a_low0_hold: assert property (
      ce && !sr_active && !(bus_in.wr && bus_in.addr == alm_pkg::ADDR_LOW0)
      |=> q.low_lim[0] == $past(q.low_lim[0])
   ) else $error("low limit zero changed without a write");

   // low limit zero reads back
   a_low0_read: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_LOW0
      |=> rd_data == $past(q.low_lim[0])
   ) else $error("low limit zero read mismatch");

   // low limit one reads back
   a_low1_read: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_LOW1
      |=> rd_data == $past(q.low_lim[1])
   ) else $error("low limit one read mismatch");

   // measured value of channel one reads back
   a_meas1_read: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_MEAS1
      |=> rd_data == $past(ch_meas[1])
   ) else $error("measured value one read mismatch");

   // channel zero captures its result
   a_meas0_capture: assert property (
      ce && !sr_active && meas_in[0].valid
      |=> ch_meas[0] == $past(meas_in[0].value)
   ) else $error("channel zero result not captured");

   // measured value holds without a new result
   a_meas_hold: assert property (
      ce && !sr_active && !meas_in[0].valid
      |=> ch_meas[0] == $past(ch_meas[0])
   ) else $error("measured value changed without a result");

   // a write to a measured register leaves it alone
   a_meas_no_write: assert property (
      ce && !sr_active && bus_in.wr && bus_in.addr == alm_pkg::ADDR_MEAS1 && !meas_in[1].valid
      |=> ch_meas[1] == $past(ch_meas[1])
   ) else $error("measured value changed by a write");

   // key write starts the soft reset
   a_key_starts_reset: assert property (
      ce && key_hit |=> sr_active
   ) else $error("key write did not start a soft reset");

   // any other value only stores
   a_other_no_reset: assert property (
      ce && bus_in.wr && !sr_active && bus_in.addr == alm_pkg::ADDR_SWRST && bus_in.wdata != alm_pkg::SWRST_KEY
      |=> !sr_active
   ) else $error("non-key value started a soft reset");

   // soft reset clears both channels
   a_soft_rst_channels: assert property (
      ce && sr_active
      |=> ch_meas[0] == alm_pkg::RST_MEAS && ch_meas[1] == alm_pkg::RST_MEAS && low_event == 2'b00
   ) else $error("soft reset left a channel set");

   // soft reset clears limits, behaviour and test register
   a_soft_rst_regs: assert property (
      ce && sr_active
      |=> q.behav == {2{alm_pkg::RST_BEHAV}} && q.low_lim == {2{alm_pkg::RST_LOW}} && q.test_reg == alm_pkg::RST_TEST
   ) else $error("soft reset left a register set");

   // key register stores what is written
   a_key_store: assert property (
      ce && bus_in.wr && !sr_active && bus_in.addr == alm_pkg::ADDR_SWRST
      |=> q.key_reg == $past(bus_in.wdata)
   ) else $error("soft reset register did not store the write");

   // key value stands while the reset runs
   a_key_held_busy: assert property (
      sr_active |-> q.key_reg == alm_pkg::SWRST_KEY
   ) else $error("key value lost during soft reset");

   // writes cannot touch the key register while the reset runs
   a_key_frozen_busy: assert property (
      ce && sr_active |=> q.key_reg == $past(q.key_reg)
   ) else $error("soft reset register changed during soft reset");

   // done follows the end of the reset
   a_done_after_busy: assert property (
      $rose(sr_done) |-> $past(sr_active)
   ) else $error("done pulse without a soft reset");

   // whole revision byte
   a_rev_full: assert property (
      ce && bus_in.rd && bus_in.addr == alm_pkg::ADDR_REV
      |=> rd_data == {REV_MAJOR, REV_MINOR}
   ) else $error("revision byte mismatch");

   // channel one event follows the chosen direction
   a_event_dir_one: assert property (
      ce && !sr_active
      |=> low_event[1] == ($past(q.behav[1][alm_pkg::BEHAV_DIR_BIT])
         ? ($past(ch_meas[1]) > $past(q.low_lim[1]))
         : ($past(ch_meas[1]) < $past(q.low_lim[1])))
   ) else $error("channel one event direction wrong");

   // a channel zero event sets its sticky bit
   a_event_latch0: assert property (
      ce && !sr_active && low_event[0] |=> fault_latched[0]
   ) else $error("channel zero fault not latched");

   // sticky bit stays until cleared by a write
   a_latch_sticky: assert property (
      ce && !sr_active && fault_latched[0] && !(bus_in.wr && bus_in.addr == alm_pkg::ADDR_BEHAV0)
      |=> fault_latched[0]
   ) else $error("channel zero fault dropped without a write");

   // writing zero clears the sticky bit when no event stands
   a_latch_clear: assert property (
      ce && !sr_active && !low_event[0] && bus_in.wr && bus_in.addr == alm_pkg::ADDR_BEHAV0
      && !bus_in.wdata[alm_pkg::BEHAV_LATCH_BIT]
      |=> !fault_latched[0]
   ) else $error("channel zero fault not cleared");
endmodule // alm_regs
`default_nettype wire

// File: rtl/alm_pkg.sv
// Purpose: shared constants and carriers for the analog limit and misc register bank
// Assumes: 8-bit register bus, 200 MHz clk_sys
// Notes: offsets are byte addresses of one byte-wide register each
package alm_pkg;
   // register offsets
   localparam logic [7:0] ADDR_SWRST = 8'h0b;
   localparam logic [7:0] ADDR_MAKER = 8'h0d;
   localparam logic [7:0] ADDR_REV = 8'h0e;
   localparam logic [7:0] ADDR_TEST = 8'h0f;
   localparam logic [7:0] ADDR_BEHAV0 = 8'h50;
   localparam logic [7:0] ADDR_BEHAV1 = 8'h51;
   localparam logic [7:0] ADDR_LOW0 = 8'hb0;
   localparam logic [7:0] ADDR_LOW1 = 8'hb1;
   localparam logic [7:0] ADDR_MEAS0 = 8'hb8;
   localparam logic [7:0] ADDR_MEAS1 = 8'hb9;
   // key and reset values
   localparam logic [7:0] SWRST_KEY = 8'ha6;
   localparam logic [7:0] RST_KEY = 8'h00;
   localparam logic [7:0] RST_LOW = 8'h00;
   localparam logic [7:0] RST_BEHAV = 8'h00;
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic [7:0] RST_MEAS = 8'h00;
   localparam logic [7:0] RD_NONE = 8'h00;
   // field positions in the behaviour and revision registers
   localparam int BEHAV_DIR_BIT = 3;
   localparam int BEHAV_LATCH_BIT = 7;
   localparam int REV_MINOR_LSB = 0;
   localparam int REV_MAJOR_LSB = 4;
   // soft reset duration
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SWRST_NS = 20;
   localparam int SWRST_CYC_INT = (SWRST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [2:0] SWRST_CYCLES = 3'(SWRST_CYC_INT < 1 ? 1 : SWRST_CYC_INT);
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } alm_bus_t;
   // one conversion result from the converter
   typedef struct packed {
      logic valid;
      logic [7:0] value;
   } alm_meas_t;
endpackage

// File: rtl/alm_chan.sv
// Purpose: one analog channel: holds the measured value and checks it against its low limit
// Assumes: measurement arrives from logic on clk_sys
// Notes: event is a level, one cycle behind the stored value
`timescale 1ns/1ps
`default_nettype none
module alm_chan (
   input wire logic clk_sys, // system clock
   input wire logic rst, // power-on or soft reset
   input wire logic ce, // clock enable
   input wire alm_pkg::alm_meas_t meas, // new conversion result
   input wire logic [7:0] low_limit, // low limit of this channel
   input wire logic above_sel, // 1: event when above limit
   output logic [7:0] measured, // latest measured value
   output logic low_event // limit crossed
);
   typedef struct packed {
      logic [7:0] measured;
      logic low_event;
   } alm_chan_state_t;
   alm_chan_state_t q;
   alm_chan_state_t next_q;

   // capture result and compare in the chosen direction
   always_comb begin
      next_q = q;
      if (meas.valid) begin
         next_q.measured = meas.value;
      end
      next_q.low_event = above_sel ? (q.measured > low_limit) : (q.measured < low_limit);
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '{measured: alm_pkg::RST_MEAS, low_event: 1'b0};
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign measured = q.measured;
   assign low_event = q.low_event;
endmodule // alm_chan
`default_nettype wire

// File: rtl/alm_swrst.sv
// Purpose: soft reset sequencer started by the key write
// Assumes: key_hit is a one-cycle pulse on clk_sys
// Notes: only the hard reset clears this module
`timescale 1ns/1ps
`default_nettype none
module alm_swrst (
   input wire logic clk_sys, // system clock
   input wire logic reset, // hard reset
   input wire logic ce, // clock enable
   input wire logic key_hit, // key value written
   output logic soft_rst, // soft reset in progress
   output logic done // one-cycle pulse at the end
);
   typedef enum logic [0:0] {
      ALM_SR_IDLE = 1'b0,
      ALM_SR_BUSY = 1'b1
   } alm_sr_state_t;
   typedef struct packed {
      alm_sr_state_t st;
      logic [2:0] cnt;
      logic soft_rst;
      logic done;
   } alm_sr_t;
   alm_sr_t q;
   alm_sr_t next_q;

   // hold soft reset for the fixed count, then pulse done
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      unique case (q.st)
         ALM_SR_IDLE: begin
            if (key_hit) begin
               next_q.st = ALM_SR_BUSY;
               next_q.cnt = alm_pkg::SWRST_CYCLES - 3'h1;
               next_q.soft_rst = 1'b1;
            end
         end
         ALM_SR_BUSY: begin
            if (q.cnt == 3'h0) begin
               next_q.st = ALM_SR_IDLE;
               next_q.soft_rst = 1'b0;
               next_q.done = 1'b1;
            end else begin
               next_q.cnt = q.cnt - 3'h1;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '{st: ALM_SR_IDLE, cnt: 3'h0, soft_rst: 1'b0, done: 1'b0};
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign soft_rst = q.soft_rst;
   assign done = q.done;
endmodule // alm_swrst
`default_nettype wire

// File: test/tb.sv
// Purpose: self-checking bench for the analog limit and misc register bank
// Assumes: bench drives the register port and conversion results directly, ce held high except during the clock enable check
// Notes: maker and revision differ from the defaults
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] T_MAKER = 8'h3c; // arbitrary value
   localparam logic [3:0] T_MAJOR = 4'h2; // major revision under test
   localparam logic [3:0] T_MINOR = 4'h7; // minor revision under test
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   alm_pkg::alm_bus_t bus_in = '0;
   alm_pkg::alm_meas_t [1:0] meas_in = '0;
   logic [7:0] rd_data;
   logic [1:0] low_event;
   logic [1:0] fault_latched;
   logic soft_reset_out;
   logic [7:0] d;
   int mismatches = 0;
   int total_checks = 0;
   int n;

   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;

   alm_regs #(.MAKER_ID(T_MAKER), .REV_MAJOR(T_MAJOR), .REV_MINOR(T_MINOR)) i_alm_regs (
      .clk_sys(clk_sys),
      .reset(reset),
      .ce(ce),
      .bus_in(bus_in),
      .meas_in(meas_in),
      .rd_data(rd_data),
      .low_event(low_event),
      .fault_latched(fault_latched),
      .soft_reset_out(soft_reset_out)
   );

   // compare and count
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_in <= '0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_in <= '0;
      #1;
      v = rd_data;
   endtask

   // read and compare
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      check(what, v, exp);
   endtask

   // one conversion result pulse on a channel
   task automatic meas(input bit ch, input logic [7:0] v);
      @(posedge clk_sys);
      meas_in[ch] <= '{valid: 1'b1, value: v};
      @(posedge clk_sys);
      meas_in[ch] <= '{valid: 1'b0, value: v};
   endtask

   // verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      #50000;
      mismatches++;
      wrap_up();
   end

   // main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      // values after power-on reset
      rd_chk("low0 reset", alm_pkg::ADDR_LOW0, 8'h00);
      rd_chk("low1 reset", alm_pkg::ADDR_LOW1, 8'h00);
      rd_chk("meas0 reset", alm_pkg::ADDR_MEAS0, 8'h00);
      rd_chk("meas1 reset", alm_pkg::ADDR_MEAS1, 8'h00);
      rd_chk("key reset", alm_pkg::ADDR_SWRST, 8'h00);
      rd_chk("test reset", alm_pkg::ADDR_TEST, 8'h00);
      rd_chk("maker", alm_pkg::ADDR_MAKER, T_MAKER);
      rd(alm_pkg::ADDR_REV, d);
      check("rev minor", {4'h0, d[3:0]}, {4'h0, T_MINOR});
      check("rev major", {4'h0, d[7:4]}, {4'h0, T_MAJOR});
      // limit writes one idle cycle apart, writes into read-only places, two conversions
      wr(alm_pkg::ADDR_LOW0, 8'h5c);
      wr(alm_pkg::ADDR_LOW1, 8'ha3);
      wr(alm_pkg::ADDR_MAKER, ~T_MAKER);
      wr(alm_pkg::ADDR_REV, 8'hff);
      meas(1'b0, 8'h40);
      meas(1'b1, 8'hc0);
      wr(alm_pkg::ADDR_MEAS0, 8'h99);
      wr(alm_pkg::ADDR_TEST, 8'h77);
      rd_chk("low0", alm_pkg::ADDR_LOW0, 8'h5c);
      rd_chk("low1", alm_pkg::ADDR_LOW1, 8'ha3);
      rd_chk("maker after write", alm_pkg::ADDR_MAKER, T_MAKER);
      rd_chk("rev after write", alm_pkg::ADDR_REV, {T_MAJOR, T_MINOR});
      rd_chk("meas0", alm_pkg::ADDR_MEAS0, 8'h40);
      rd_chk("meas1", alm_pkg::ADDR_MEAS1, 8'hc0);
      rd_chk("test", alm_pkg::ADDR_TEST, 8'h77);
      rd_chk("unmapped", 8'h33, 8'h00);
      @(posedge clk_sys);
      #1;
      check("rd_data idle", rd_data, 8'h00);
      // direction bits clear: an event when below the low limit
      check("events below", {6'h00, low_event}, 8'h01);
      wr(alm_pkg::ADDR_BEHAV0, 8'h08);
      wr(alm_pkg::ADDR_BEHAV1, 8'h08);
      repeat (3) @(posedge clk_sys);
      #1;
      check("events above", {6'h00, low_event}, 8'h02);
      check("faults set", {6'h00, fault_latched}, 8'h03);
      rd_chk("behav0 latched", alm_pkg::ADDR_BEHAV0, 8'h88);
      // a value other than the key is only stored
      wr(alm_pkg::ADDR_SWRST, 8'h12);
      #1;
      check("no soft reset", {7'h00, soft_reset_out}, 8'h00);
      rd_chk("key stored", alm_pkg::ADDR_SWRST, 8'h12);
      // key write: soft reset for a fixed span, then everything back to reset values
      wr(alm_pkg::ADDR_SWRST, alm_pkg::SWRST_KEY);
      n = 0;
      repeat (8) begin
         #1;
         if (soft_reset_out === 1'b1) n++;
         @(posedge clk_sys);
      end
      check("soft reset length", 8'(n), {5'h00, alm_pkg::SWRST_CYCLES});
      rd_chk("key cleared", alm_pkg::ADDR_SWRST, 8'h00);
      rd_chk("low0 soft", alm_pkg::ADDR_LOW0, 8'h00);
      rd_chk("low1 soft", alm_pkg::ADDR_LOW1, 8'h00);
      rd_chk("meas0 soft", alm_pkg::ADDR_MEAS0, 8'h00);
      rd_chk("meas1 soft", alm_pkg::ADDR_MEAS1, 8'h00);
      rd_chk("test soft", alm_pkg::ADDR_TEST, 8'h00);
      rd_chk("behav0 soft", alm_pkg::ADDR_BEHAV0, 8'h00);
      rd_chk("maker soft", alm_pkg::ADDR_MAKER, T_MAKER);
      check("events soft", {6'h00, low_event}, 8'h00);
      check("faults soft", {6'h00, fault_latched}, 8'h00);
      // clock enable low freezes the bank
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(alm_pkg::ADDR_LOW1, 8'h3e);
      ce <= 1'b1;
      rd_chk("low1 frozen", alm_pkg::ADDR_LOW1, 8'h00);
      // limits work again after the soft reset
      wr(alm_pkg::ADDR_LOW1, 8'he1);
      rd_chk("low1 again", alm_pkg::ADDR_LOW1, 8'he1);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
